// ==== hdl/gst_pkg.sv ====
// gst_pkg: constants, register map and types of the gated 16-bit timer
// assumes a 32-bit AXI4-Lite register bus and one 200 MHz system clock
package gst_pkg;

    // -------------------------------------------------------------
    // clock and divider
    // -------------------------------------------------------------
    localparam int        CLK_MHZ        = 200;
    localparam int        INSTR_DIV      = 4;
    localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1);

    // -------------------------------------------------------------
    // register byte addresses
    // -------------------------------------------------------------
    localparam logic [5:0] ADDR_CONTROL  = 6'h00;
    localparam logic [5:0] ADDR_COUNT_LO = 6'h04;
    localparam logic [5:0] ADDR_COUNT_HI = 6'h08;
    localparam logic [5:0] ADDR_AUX      = 6'h0c;
    localparam logic [5:0] ADDR_FLAG     = 6'h10;
    localparam logic [5:0] ADDR_IRQ_EN   = 6'h14;
    localparam logic [5:0] ADDR_CCP_VAL  = 6'h18;
    localparam logic [5:0] ADDR_CCP_MODE = 6'h1c;

    // -------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------
    localparam int AUX_GATE_SRC_BIT  = 1;
    localparam int AUX_CMP_SYNC_BIT  = 0;
    localparam int FLAG_OVF_BIT      = 0;
    localparam int EN_OVF_BIT        = 0;
    localparam int EN_PERIPH_BIT     = 1;
    localparam int EN_GLOBAL_BIT     = 2;
    localparam int MODE_CAPTURE_BIT  = 0;
    localparam int MODE_COMPARE_BIT  = 1;
    localparam int MODE_SPECIAL_BIT  = 2;

    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;
    localparam logic [2:0]  PRESCALE_ZERO = 3'h0;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // -------------------------------------------------------------
    // control register layout, bit 7 down to bit 0
    // -------------------------------------------------------------
    typedef struct packed {
        logic       gate_polarity;
        logic       gate_enable_ctl;
        logic [1:0] input_prescale_select;
        logic       lp_osc_enable;
        logic       sync_bypass;
        logic       clock_source_select;
        logic       timer_on;
    } gst_control_t;

    // -------------------------------------------------------------
    // capture/compare side
    // -------------------------------------------------------------
    typedef struct packed {
        logic special;
        logic compare;
        logic capture;
    } gst_ccp_mode_t;

endpackage

// ==== hdl/gst_timer.sv ====
// gst_timer: gated 16-bit timer/counter with prescaler, sleep wake and capture/compare time base
// assumes AXI4-Lite master on clk; pins arrive asynchronously and are synchronised here
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps

// What this block does
// - count byte reads always stable and valid
// - gated counting from pin or comparator
// - bit 7 selects gate active level
// - bit 6 enables gating while on
// - wrap to zero sets overflow flag
// - interrupt needs on and three enables
// - flag sticky until software clears it
// - sleep counting only external with sync_bypass
// - sleep overflow wakes, vectors if global
// - capture copies count on event
// - compare match raises an event
// - special trigger clears count, no flag
// - count write beats special clear
// - comparator gate resynced to timer clock
// - bits 5-4 prescale 1,2,4,8
// - bit 3 low-power oscillator conditional
// - bit 2 lets external clock count in sleep
// - bit 1 selects pin or instruction clock
// - falling edge needed before first rising
// - reset clears control register
// - count write clears hidden prescaler
module gst_timer
    import gst_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        externalCountClock,
    input  wire logic        lpOscClock,
    input  wire logic        intOscNoClkout,
    input  wire logic        gatePin,
    input  wire logic        comparatorTwoOutput,
    input  wire logic        captureEventPin,
    input  wire logic        sleepMode,
    output logic             irqRequest,
    output logic             wakeRequest,
    output logic             vectorRequest,
    output logic             compareEvent
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    gst_control_t  control;
    gst_ccp_mode_t ccpMode;
    logic [15:0]   count;
    logic [15:0]   captureCompareValue;
    logic          gateSourceSelect;
    logic          comparatorSyncEnable;
    logic          overflowFlag;
    logic          overflowIrqEnable;
    logic          peripheralIrqEnable;
    logic          globalIrqEnable;
    logic [2:0]    prescale;
    logic [1:0]    instrDiv;
    logic          armed;
    logic          prevOn;
    logic          prevPinLevel;
    logic          prevCapture;
    logic          compMatchPrev;
    logic          comparatorLatched;

    logic [5:0]    wrAddr;
    logic [31:0]   wrData;
    logic [3:0]    wrStrb;
    logic          haveAw;
    logic          haveW;

    // -------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------
    logic [4:0] pinMeta;
    logic [4:0] pinSync;
    logic [4:0] pinRaw;

    assign pinRaw = {captureEventPin, comparatorTwoOutput, gatePin, lpOscClock, externalCountClock};

    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : gen_sync
            always_ff @(posedge clk)
            begin
                pinMeta[g] <= pinRaw[g];
                pinSync[g] <= pinMeta[g];
            end
        end
    endgenerate

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic isCountAddr(input logic [5:0] a);
        isCountAddr = (a == ADDR_COUNT_LO) || (a == ADDR_COUNT_HI);
    endfunction

    function automatic logic isMapped(input logic [5:0] a);
        isMapped = (a == ADDR_CONTROL) || isCountAddr(a) || (a == ADDR_AUX) || (a == ADDR_FLAG)
                || (a == ADDR_IRQ_EN) || (a == ADDR_CCP_VAL) || (a == ADDR_CCP_MODE);
    endfunction

    // -------------------------------------------------------------
    // axi write path
    // -------------------------------------------------------------
    logic wrFire;
    logic wrHit;
    logic countWrite;

    assign wrFire     = haveAw && haveW && !s_axi_bvalid;
    assign wrHit      = wrFire && wrStrb[0];
    assign countWrite = wrHit && isCountAddr(wrAddr);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            haveAw        <= 1'b0;
            haveW         <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            wrAddr        <= ADDR_CONTROL;
            wrData        <= 32'h0000_0000;
            wrStrb        <= 4'h0;
        end
        else
        begin
            s_axi_awready <= !haveAw && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !haveW && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                haveAw <= 1'b1;
                wrAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                haveW  <= 1'b1;
                wrData <= s_axi_wdata;
                wrStrb <= s_axi_wstrb;
            end
            if (wrFire)
            begin
                haveAw       <= 1'b0;
                haveW        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= isMapped(wrAddr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------
    // software registers
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            control              <= CONTROL_RESET;
            gateSourceSelect     <= 1'b0;
            comparatorSyncEnable <= 1'b0;
            overflowIrqEnable    <= 1'b0;
            peripheralIrqEnable  <= 1'b0;
            globalIrqEnable      <= 1'b0;
            ccpMode              <= '0;
        end
        else if (wrHit)
        begin
            case (wrAddr)
                ADDR_CONTROL:  control <= gst_control_t'(wrData[7:0]);
                ADDR_AUX:
                begin
                    gateSourceSelect     <= wrData[AUX_GATE_SRC_BIT];
                    comparatorSyncEnable <= wrData[AUX_CMP_SYNC_BIT];
                end
                ADDR_IRQ_EN:
                begin
                    overflowIrqEnable   <= wrData[EN_OVF_BIT];
                    peripheralIrqEnable <= wrData[EN_PERIPH_BIT];
                    globalIrqEnable     <= wrData[EN_GLOBAL_BIT];
                end
                ADDR_CCP_MODE: ccpMode <= gst_ccp_mode_t'(wrData[2:0]);
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // clock source and input tick
    // -------------------------------------------------------------
    logic useLpOsc;
    logic pinLevel;
    logic instrTick;
    logic pinRise;
    logic pinFall;
    logic inputTick;
    logic sleepHalt;

    assign useLpOsc  = control.lp_osc_enable && intOscNoClkout;
    assign pinLevel  = useLpOsc ? pinSync[1] : pinSync[0];
    assign instrTick = (instrDiv == INSTR_DIV_LAST);
    assign pinRise   = pinLevel && !prevPinLevel;
    assign pinFall   = !pinLevel && prevPinLevel;
    // sync_bypass only changes sleep behaviour: pin is always resampled on clk
    assign sleepHalt = sleepMode && !(control.clock_source_select && control.sync_bypass);
    assign inputTick = control.clock_source_select ? (pinRise && armed) : instrTick;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            instrDiv     <= 2'b00;
            prevPinLevel <= 1'b0;
            prevOn       <= 1'b0;
        end
        else
        begin
            instrDiv     <= instrDiv + 2'b01;
            prevPinLevel <= pinLevel;
            prevOn       <= control.timer_on;
        end
    end

    // falling edge must be seen before the first counted rising edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            armed <= 1'b0;
        end
        else if (countWrite || !control.timer_on || (control.timer_on && !prevOn))
        begin
            armed <= 1'b0;
        end
        else if (pinFall)
        begin
            armed <= 1'b1;
        end
    end

    // -------------------------------------------------------------
    // gate
    // -------------------------------------------------------------
    logic gateSource;
    logic gateActive;
    logic countEnable;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            comparatorLatched <= 1'b0;
        end
        else if (inputTick)
        begin
            comparatorLatched <= pinSync[3];
        end
    end

    assign gateSource  = gateSourceSelect
                       ? (comparatorSyncEnable ? comparatorLatched : pinSync[3])
                       : pinSync[2];
    assign gateActive  = control.gate_polarity ? gateSource : !gateSource;
    assign countEnable = control.timer_on && (!control.gate_enable_ctl || gateActive) && !sleepHalt;

    // -------------------------------------------------------------
    // prescaler and counter
    // -------------------------------------------------------------
    logic [2:0] prescaleMask;
    logic       countTick;
    logic       compareMatch;
    logic       specialClear;

    always_comb
    begin
        case (control.input_prescale_select)
            2'b00:   prescaleMask = 3'h0;
            2'b01:   prescaleMask = 3'h1;
            2'b10:   prescaleMask = 3'h3;
            2'b11:   prescaleMask = 3'h7;
            default: prescaleMask = 3'h0;
        endcase
    end

    assign countTick    = countEnable && inputTick && ((prescale & prescaleMask) == prescaleMask);
    assign compareMatch = ccpMode.compare && (count == captureCompareValue);
    assign specialClear = compareMatch && !compMatchPrev && ccpMode.special;

    always_ff @(posedge clk)
    begin
        if (rst || countWrite)
        begin
            prescale <= PRESCALE_ZERO;
        end
        else if (countEnable && inputTick)
        begin
            prescale <= prescale + 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count <= COUNT_RESET;
        end
        else if (countWrite)
        begin
            // write wins over special clear and increment
            if (wrAddr == ADDR_COUNT_LO)
            begin
                count[7:0] <= wrData[7:0];
            end
            else
            begin
                count[15:8] <= wrData[7:0];
            end
        end
        else if (specialClear)
        begin
            count <= COUNT_RESET;
        end
        else if (countTick)
        begin
            count <= count + 16'h0001;
        end
    end

    // -------------------------------------------------------------
    // overflow flag, set wins over clear
    // -------------------------------------------------------------
    logic overflowSet;

    assign overflowSet = countTick && !countWrite && !specialClear && (count == COUNT_MAX);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            overflowFlag <= 1'b0;
        end
        else if (overflowSet)
        begin
            overflowFlag <= 1'b1;
        end
        else if (wrHit && wrAddr == ADDR_FLAG && !wrData[FLAG_OVF_BIT])
        begin
            overflowFlag <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // capture/compare time base
    // -------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            captureCompareValue <= COUNT_RESET;
            prevCapture         <= 1'b0;
            compMatchPrev       <= 1'b0;
            compareEvent        <= 1'b0;
        end
        else
        begin
            prevCapture   <= pinSync[4];
            compMatchPrev <= compareMatch;
            compareEvent  <= compareMatch && !compMatchPrev;
            if (ccpMode.capture && pinSync[4] && !prevCapture)
            begin
                captureCompareValue <= count;
            end
            else if (wrFire && wrAddr == ADDR_CCP_VAL)
            begin
                if (wrStrb[0])
                begin
                    captureCompareValue[7:0] <= wrData[7:0];
                end
                if (wrStrb[1])
                begin
                    captureCompareValue[15:8] <= wrData[15:8];
                end
            end
        end
    end

    // -------------------------------------------------------------
    // interrupt and wake outputs
    // -------------------------------------------------------------
    logic wakeCond;

    assign wakeCond = sleepMode && overflowFlag && overflowIrqEnable && peripheralIrqEnable;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irqRequest    <= 1'b0;
            wakeRequest   <= 1'b0;
            vectorRequest <= 1'b0;
        end
        else
        begin
            irqRequest    <= control.timer_on && overflowFlag && overflowIrqEnable
                          && peripheralIrqEnable && globalIrqEnable;
            wakeRequest   <= wakeCond;
            vectorRequest <= wakeCond && globalIrqEnable;
        end
    end

    // -------------------------------------------------------------
    // axi read path; count is in clk domain so both bytes read stable
    // -------------------------------------------------------------
    logic [31:0] readValue;

    always_comb
    begin
        readValue = 32'h0000_0000;
        case (s_axi_araddr)
            ADDR_CONTROL:  readValue[7:0] = control;
            ADDR_COUNT_LO: readValue[7:0] = count[7:0];
            ADDR_COUNT_HI: readValue[7:0] = count[15:8];
            ADDR_AUX:
            begin
                readValue[AUX_GATE_SRC_BIT] = gateSourceSelect;
                readValue[AUX_CMP_SYNC_BIT] = comparatorSyncEnable;
            end
            ADDR_FLAG:     readValue[FLAG_OVF_BIT] = overflowFlag;
            ADDR_IRQ_EN:
            begin
                readValue[EN_OVF_BIT]    = overflowIrqEnable;
                readValue[EN_PERIPH_BIT] = peripheralIrqEnable;
                readValue[EN_GLOBAL_BIT] = globalIrqEnable;
            end
            ADDR_CCP_VAL:  readValue[15:0] = captureCompareValue;
            ADDR_CCP_MODE: readValue[2:0] = ccpMode;
            default:       readValue = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= readValue;
                s_axi_rresp   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ==== verif/gst_timer_checker.sv ====
// gst_timer_checker: port-level relations of gst_timer
// assumes one clk domain, synchronous rst
`timescale 1ns/10ps
module gst_timer_checker
(
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleepMode,
    input wire logic wakeRequest,
    input wire logic vectorRequest,
    input wire logic compareEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------
    // assertions
    // ------------------------
    a_vector_needs_wake: assert property (vectorRequest |-> wakeRequest)
        else $error("vector without wake");
    a_wake_after_sleep: assert property (wakeRequest |-> $past(sleepMode))
        else $error("wake while awake");
    a_compare_pulse: assert property (compareEvent |=> !compareEvent)
        else $error("compare pulse too long");
    a_write_answer: assert property (s_axi_awready && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    a_aw_taken: assert property (s_axi_awvalid && !s_axi_awready && !s_axi_bvalid |-> ##[1:2] s_axi_awready)
        else $error("awaddr not taken");
    a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
        else $error("no read data");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
endmodule

bind gst_timer gst_timer_checker u_chk (.*);

// ==== verif/gst_pin_model.sv ====
// gst_pin_model: external count clock, gate pin and comparator output
// assumes clk of the bench; pin clock stands low outside bursts
`timescale 1ns/10ps
module gst_pin_model
#(
    parameter int HALF = 8
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic gateLvl,
    input  wire logic cmpLvl,
    output logic      externalCountClock,
    output logic      gatePin,
    output logic      comparatorTwoOutput
);
    int phase;
    // ------------------------
    // burst clock, rising edge first
    // ------------------------
    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            phase <= 0;
            externalCountClock <= 1'b0;
        end
        else if (phase == HALF - 1)
        begin
            phase <= 0;
            externalCountClock <= !externalCountClock;
        end
        else
            phase <= phase + 1;
    end
    always_ff @(posedge clk)
    begin
        gatePin <= gateLvl;
        comparatorTwoOutput <= cmpLvl;
    end
endmodule

// ==== verif/testbench.sv ====
// testbench: self-checking bench of gst_timer
// assumes gst_pkg map; bench is the AXI4-Lite master
`timescale 1ns/10ps
module testbench
    import gst_pkg::*;
;
    logic        clk, rst, extRun, gateLvl, cmpLvl, sleepMode, lpOscClock, intOscNoClkout, captureEventPin;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        externalCountClock, gatePin, comparatorTwoOutput;
    logic        irqRequest, wakeRequest, vectorRequest, compareEvent;
    int          errCount, numChecks, seed, i, n, k;
    logic [31:0] gCtl = 32'h81c141c1;

    gst_timer u_dut (.*);
    gst_pin_model u_pins (.clk, .rst, .run(extRun), .gateLvl, .cmpLvl, .externalCountClock, .gatePin,
                          .comparatorTwoOutput);

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ------------------------
    // bus tasks and comparison
    // ------------------------
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        numChecks++;
        if (s !== e)
        begin
            $display("BAD %s exp %h saw %h", nm, e, s);
            errCount++;
        end
    endtask
    task automatic lim(input int t, input int m);
        if (t >= m)
        begin
            $display("BAD wait exp %0d saw %0d", m, t);
            errCount++;
            finalReport();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        bit ga, gw, gb;
        int t;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        gb = 0;
        for (t = 0; t < 50 && !gb; t++)
        begin
            @(negedge clk);
            ga = s_axi_awready === 1'b1;
            gw = s_axi_wready === 1'b1;
            gb = s_axi_bvalid === 1'b1;
            @(posedge clk);
            if (ga) s_axi_awvalid <= 1'b0;
            if (gw) s_axi_wvalid <= 1'b0;
            if (gb) s_axi_bready <= 1'b0;
        end
        lim(t, 50);
    endtask
    task automatic rd(input logic [5:0] a);
        bit ga, gr;
        int t;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        gr = 0;
        for (t = 0; t < 50 && !gr; t++)
        begin
            @(negedge clk);
            ga = s_axi_arready === 1'b1;
            gr = s_axi_rvalid === 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ga) s_axi_arvalid <= 1'b0;
            if (gr) s_axi_rready <= 1'b0;
        end
        lim(t, 50);
    endtask
    task automatic finalReport;
        $display("checks %0d errors %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ------------------------
    // main sequence
    // ------------------------
    initial
    begin
        seed = 10729;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {extRun, gateLvl, cmpLvl, sleepMode, lpOscClock, intOscNoClkout, captureEventPin} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {errCount, numChecks} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CONTROL);
        chk("control reset", d, 32'h0);
        rd(6'h3c);
        chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
        for (i = 0; i < 4; i++)
        begin
            n = 200 + ($random(seed) & 255);
            wr(ADDR_COUNT_LO, 32'h0);
            wr(ADDR_COUNT_HI, 32'h0);
            wr(ADDR_CONTROL, {26'h0, i[1:0], 4'h1});
            repeat (n) @(posedge clk);
            wr(ADDR_CONTROL, 32'h0);
            rd(ADDR_COUNT_LO);
            chk("prescale", 32'(int'(d[7:0]) >= n / (4 << i) - 1 && int'(d[7:0]) <= (n + 8) / (4 << i) + 1), 32'h1);
        end
        for (i = 0; i < 4; i++)
        begin
            gateLvl <= i[1];
            cmpLvl <= !i[1];
            wr(ADDR_AUX, {30'h0, {2{i[1]}}});
            wr(ADDR_COUNT_LO, 32'h0);
            wr(ADDR_CONTROL, 32'(gCtl[8*i+:8]));
            repeat (100) @(posedge clk);
            wr(ADDR_CONTROL, 32'h0);
            rd(ADDR_COUNT_LO);
            chk("gated", 32'(d[7:0] != 8'h0), 32'(i[0]));
        end
        wr(ADDR_IRQ_EN, 32'h7);
        wr(ADDR_FLAG, 32'h0);
        wr(ADDR_COUNT_LO, 32'(8'hf0 | ($random(seed) & 15)));
        wr(ADDR_COUNT_HI, 32'hff);
        wr(ADDR_CONTROL, 32'h1);
        for (n = 0; n < 400 && irqRequest !== 1'b1; n++) @(negedge clk);
        lim(n, 400);
        rd(ADDR_FLAG);
        chk("flag set", 32'(d[0]), 32'h1);
        rd(ADDR_COUNT_HI);
        chk("wrap", 32'(d[7:0]), 32'h0);
        wr(ADDR_CONTROL, 32'h0);
        repeat (3) @(negedge clk);
        chk("irq off", 32'(irqRequest), 32'h0);
        rd(ADDR_FLAG);
        chk("flag held", 32'(d[0]), 32'h1);
        wr(ADDR_FLAG, 32'h0);
        rd(ADDR_FLAG);
        chk("flag cleared", 32'(d[0]), 32'h0);
        wr(ADDR_CCP_VAL, 32'h10);
        wr(ADDR_CCP_MODE, 32'h6);
        wr(ADDR_COUNT_LO, 32'h0);
        wr(ADDR_CONTROL, 32'h1);
        k = 0;
        repeat (400)
        begin
            @(negedge clk);
            k += int'(compareEvent === 1'b1);
        end
        chk("compare", 32'(k > 2), 32'h1);
        rd(ADDR_COUNT_LO);
        chk("period", 32'(d[7:0] <= 8'h10), 32'h1);
        rd(ADDR_FLAG);
        chk("no flag", 32'(d[0]), 32'h0);
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_CCP_MODE, 32'h0);
        sleepMode <= 1'b1;
        wr(ADDR_COUNT_LO, 32'h5a);
        wr(ADDR_CONTROL, 32'h1);
        repeat (100) @(posedge clk);
        rd(ADDR_COUNT_LO);
        chk("sleep halt", 32'(d[7:0]), 32'h5a);
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_COUNT_LO, 32'hfe);
        wr(ADDR_COUNT_HI, 32'hff);
        wr(ADDR_CONTROL, 32'h7);
        extRun <= 1'b1;
        repeat (66) @(posedge clk);
        extRun <= 1'b0;
        repeat (8) @(negedge clk);
        chk("wake", 32'({wakeRequest, vectorRequest}), 32'h3);
        rd(ADDR_COUNT_LO);
        chk("pin count", 32'(d[7:0]), 32'h1);
        sleepMode <= 1'b0;
        finalReport();
    end
endmodule
